// File: dv/casa_adapter_sva.sv
/* port assertions for the serial adapter.
   assumes a bind onto casa_adapter and the shared command codes. */
`timescale 1ns/1ps
`include "casa_regs.vh"
module casa_adapter_sva (
  // clock and reset
  input wire       CLK_I,
  input wire       RESET_N_I,
  // command port
  input wire       CMD_STB_I,
  input wire [2:0] CMD_CODE_I,
  input wire [7:0] CMD_DATA_I,
  input wire [7:0] RDATA_O,
  input wire       RDATA_VALID_O,
  // requests and lines
  input wire       IRQ_TX_O,
  input wire       IRQ_RX_O,
  input wire       TXD_O,
  input wire       RTS_O,
  input wire       DTR_O,
  input wire       CTS_I,
  input wire       DSR_I
);
  logic sel_q; // adapter selected
  logic brk_q; // break held
  wire  ok  = CMD_STB_I && sel_q; // command taken
  wire  st  = ok && CMD_CODE_I == `CASA_CMD_STATUS;
  wire  qry = st || (ok && CMD_CODE_I == `CASA_CMD_READ);
  wire  clr = ok && CMD_CODE_I == `CASA_CMD_CLEAR;
  wire  mdm = ok && CMD_CODE_I == `CASA_CMD_MODEM;
  // follow selection and break request
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sel_q <= 1'b0;
      brk_q <= 1'b0;
    end else begin
      if (CMD_STB_I && CMD_CODE_I == `CASA_CMD_SEL) sel_q <= CMD_DATA_I == `CASA_SEL_CODE;
      if (mdm) brk_q <= CMD_DATA_I[3];
      if (clr) brk_q <= 1'b0;
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  a_answer_next: assert property (qry |=> RDATA_VALID_O) else $error("no answer");
  a_answer_cause: assert property (RDATA_VALID_O |-> $past(qry)) else $error("stray");
  a_status_lines: assert property (RDATA_VALID_O && $past(st) |->
    RDATA_O[4:0] == {$past(CTS_I), 2'b00, $past(DSR_I), 1'b0}) else $error("modem status");
  a_clear_effect: assert property (clr ##1 !CMD_STB_I |=>
    IRQ_TX_O && !IRQ_RX_O && !RTS_O && !DTR_O && TXD_O) else $error("clear");
  a_write_drop: assert property (ok && CMD_CODE_I == `CASA_CMD_WRITE && IRQ_TX_O &&
    !$past(CMD_STB_I) |-> ##2 !IRQ_TX_O) else $error("tx request kept");
  a_busy_hold: assert property ($fell(IRQ_TX_O) |-> !IRQ_TX_O [*8]) else $error("short");
  // outputs follow the modem byte two edges after the strobe
  a_modem_outs: assert property (mdm ##1 !(clr || mdm) |=>
    RTS_O == $past(CMD_DATA_I[0], 2) && DTR_O == $past(CMD_DATA_I[1], 2))
    else $error("modem outputs");
  a_idle_high: assert property (IRQ_TX_O && !brk_q && !$past(brk_q) |-> TXD_O)
    else $error("idle low");
  a_break_low: assert property (brk_q && $past(brk_q) |-> !TXD_O) else $error("break");
  // main scenarios reached
  c_status: cover property (st ##1 RDATA_VALID_O);
  c_tx_busy: cover property ($fell(IRQ_TX_O));
  c_rx_ready: cover property ($rose(IRQ_RX_O));
endmodule // casa_adapter_sva
bind casa_adapter casa_adapter_sva u_casa_adapter_sva (
  .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .CMD_STB_I(CMD_STB_I), .CMD_CODE_I(CMD_CODE_I),
  .CMD_DATA_I(CMD_DATA_I), .RDATA_O(RDATA_O), .RDATA_VALID_O(RDATA_VALID_O),
  .IRQ_TX_O(IRQ_TX_O), .IRQ_RX_O(IRQ_RX_O), .TXD_O(TXD_O), .RTS_O(RTS_O), .DTR_O(DTR_O),
  .CTS_I(CTS_I), .DSR_I(DSR_I));

// File: dv/casa_modem_model.sv
/* behavioural modem on the serial lines.
   assumes the bench sets the frame fields before traffic. */
`timescale 1ns/1ps
module casa_modem_model (
  // clock
  input  wire  clk_i,
  // serial lines
  input  wire  txd_i,
  output logic rxd_o
);
  int         bit_cyc = 2080; // cycles per bit
  int         nbits   = 7;    // data bits
  int         nstop   = 1;    // stop bits
  bit         par_en  = 1;    // parity present
  bit         even    = 0;    // even parity
  bit         listen  = 0;    // capture enabled
  logic [7:0] got;            // last captured byte
  logic       got_par;        // its parity bit
  logic       stop_ok;        // stop bits high
  int         n_got   = 0;    // frames captured
  initial rxd_o = 1'b1; // line idles high
  // hold one bit on the line
  task automatic put(input logic b);
    rxd_o = b;
    repeat (bit_cyc) @(negedge clk_i);
  endtask
  // send a frame, optionally with bad parity or stop
  task automatic send(input logic [7:0] d, input bit bp, input bit bs);
    @(negedge clk_i);
    put(1'b0);
    for (int i = 0; i < nbits; i++) put(d[i]);
    if (par_en) put(^d[6:0] ^ (nbits == 8 && d[7]) ^ !even ^ bp);
    put(!bs);
    if (nstop == 2) put(1'b1);
    rxd_o = 1'b1;
  endtask
  // capture adapter frames mid-bit
  initial begin
    forever begin
      @(negedge txd_i iff listen);
      got = 8'h00;
      stop_ok = 1'b1;
      repeat (bit_cyc / 2) @(posedge clk_i);
      for (int i = 0; i < nbits + par_en + nstop; i++) begin
        repeat (bit_cyc) @(posedge clk_i);
        if (i < nbits) got[i] = txd_i;
        else if (i == nbits && par_en) got_par = txd_i;
        else stop_ok = stop_ok & txd_i;
      end
      n_got++;
    end
  end
endmodule // casa_modem_model

// File: dv/tb_top.sv
/* self-checking bench for the serial adapter.
   assumes the modem model and the checker bind. */
`timescale 1ns/1ps
`include "casa_regs.vh"
module tb_top;
  logic       clk, rst_n, stb, vld, irq_rx, irq_tx, txd, rxd, rts, dtr, cts, dsr;
  logic [2:0] code;
  logic [7:0] data, rdat, v, msk;
  int         seed, err_count, n_compared, k, n0;
  casa_adapter #(.FIFO_DEPTH(8)) u_casa_adapter (
    .CLK_I(clk), .RESET_N_I(rst_n), .CMD_STB_I(stb), .CMD_CODE_I(code), .CMD_DATA_I(data),
    .RDATA_O(rdat), .RDATA_VALID_O(vld), .IRQ_RX_O(irq_rx), .IRQ_TX_O(irq_tx), .TXD_O(txd),
    .RXD_I(rxd), .RTS_O(rts), .DTR_O(dtr), .CTS_I(cts), .DSR_I(dsr));
  casa_modem_model u_casa_modem_model (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));
  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // expected status byte
  function automatic logic [7:0] st(input logic rx, input logic tx, input logic er);
    return {rx, tx, er, cts, 2'b00, dsr, 1'b0};
  endfunction
  task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  // one strobed command, data scrambled afterwards
  task automatic cmd(input logic [2:0] c, input logic [7:0] d);
    @(negedge clk);
    stb = 1'b1;
    code = c;
    data = d;
    @(negedge clk);
    stb = 1'b0;
    data = 8'($random(seed));
  endtask
  task automatic query(input logic [7:0] e);
    cmd(`CASA_CMD_STATUS, 8'h00);
    check("status", e, rdat);
    check("answer", 8'h01, {7'h00, vld});
  endtask
  task automatic wait_bit(ref logic s);
    for (k = 0; k < 3000 && s !== 1'b1; k++) @(negedge clk);
  endtask
  // full-duplex frame pair; only 9600 and 19200 codes used
  task automatic pair(input logic [7:0] p, input bit wr, input bit bp, input bit bs);
    logic [7:0] t, r;
    t = 8'($random(seed));
    r = 8'($random(seed));
    if (wr) cmd(`CASA_CMD_PARAM, p);
    msk = p[6] ? 8'hff : 8'h7f;
    u_casa_modem_model.nbits = p[6] ? 8 : 7;
    u_casa_modem_model.nstop = p[7] ? 2 : 1;
    u_casa_modem_model.par_en = !p[5];
    u_casa_modem_model.even = p[4];
    u_casa_modem_model.bit_cyc = 16 * ((20000000 + 8 * (p[0] ? 19200 : 9600)) / (p[0] ? 307200 : 153600));
    check("tx ready", 8'h01, {7'h00, irq_tx});
    fork
      u_casa_modem_model.send(r, bp, bs);
      begin
        n0 = u_casa_modem_model.n_got;
        cmd(`CASA_CMD_WRITE, t);
        repeat (3) @(negedge clk);
        check("tx busy", 8'h00, {7'h00, irq_tx});
        for (k = 0; k < 30000 && u_casa_modem_model.n_got == n0; k++) @(negedge clk);
        check("tx data", t & msk, u_casa_modem_model.got);
        if (!p[5]) check("tx parity", {7'h00, ^(t & msk) ^ !p[4]},
                         {7'h00, u_casa_modem_model.got_par});
        check("tx stop", 8'h01, {7'h00, u_casa_modem_model.stop_ok});
        repeat (u_casa_modem_model.bit_cyc) @(negedge clk);
        check("tx again", 8'h01, {7'h00, irq_tx});
      end
    join
    wait_bit(irq_rx);
    check("rx request", 8'h01, {7'h00, irq_rx});
    query(st(1'b1, 1'b1, bp | bs));
    cmd(`CASA_CMD_READ, 8'h00);
    check("rx data", r & msk, rdat);
    repeat (2) @(negedge clk);
    check("rx cleared", 8'h00, {7'h00, irq_rx});
    $display("test frame pair %h finished", p);
  endtask
  task results;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // cut a hang short
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    results();
  end
  initial begin
    seed = 32'h36f3;
    {err_count, n_compared, rst_n, stb, code, data, cts, dsr} = '0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    cmd(`CASA_CMD_STATUS, 8'h00);
    check("unselected", 8'h00, {7'h00, vld});
    cmd(`CASA_CMD_SEL, `CASA_SEL_CODE);
    cmd(`CASA_CMD_CLEAR, 8'h00);
    for (int i = 0; i < 4; i++) begin
      {cts, dsr} = 2'($random(seed));
      query(st(1'b0, 1'b1, 1'b0));
    end
    cmd(`CASA_CMD_SEL, 8'he1);
    cmd(`CASA_CMD_STATUS, 8'h00);
    check("deselected", 8'h00, {7'h00, vld});
    cmd(`CASA_CMD_SEL, `CASA_SEL_CODE);
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      cmd(`CASA_CMD_MODEM, v);
      @(negedge clk);
      check("modem lines", {5'h00, v[1:0], ~v[3]}, {5'h00, dtr, rts, txd});
    end
    cmd(`CASA_CMD_CLEAR, 8'h00);
    @(negedge clk);
    check("cleared lines", 8'h01, {5'h00, dtr, rts, txd});
    query(st(1'b0, 1'b1, 1'b0));
    $display("test commands finished");
    u_casa_modem_model.listen = 1'b1;
    pair(8'h0e, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 16; i++) cmd(`CASA_CMD_PARAM, {4'h5, 4'(i)});
    pair(8'h5f, 1'b1, 1'b1, 1'b0);
    query(st(1'b0, 1'b1, 1'b1));
    pair(8'h5f, 1'b1, 1'b0, 1'b0);
    pair(8'haf, 1'b1, 1'b0, 1'b1);
    results();
  end
endmodule // tb_top

// File: hw/casa_adapter.v
/*
  command-driven full-duplex start-stop serial adapter with modem lines.
  assumes commands arrive as one-cycle strobes synchronous to CLK_I and
  modem inputs already synchronous to CLK_I.
*/
// What this block does
// [RULE1] full duplex serial transmit and receive concurrently
// [RULE2] select code f0 makes adapter active
// [RULE3] stays selected until other select; else ignore
// [RULE4] clear aborts, clears rx, error, modem outputs; rx fifo not flushed, a queued char sets avail and its error again
// [RULE5] clear sets transmit-needed flag
// [RULE6] host clears first when state uncertain
// [RULE7] status: rx avail, tx needed, error bits
// [RULE8] error flag holds until next character received
// [RULE9] status bits 4..0 follow modem inputs
// [RULE10] write loads byte, clears tx-needed until sent
// [RULE11] host writes only when character needed
// [RULE12] read returns last character, clears avail
// [RULE13] host reads only when character available
// [RULE14] modem byte: break, dtr, rts outputs
// [RULE15] parameter byte: stops, length, parity enable, even
// [RULE16] low nibble selects one of sixteen baud rates
// [RULE17] framing and baud persist until rewritten
// [RULE18] level 2 request mirrors rx available
// [RULE19] level 1 request mirrors tx needed
// [RULE20] frame: start low, lsb first, parity, stops
// [RULE21] error on parity, stop or overrun
`timescale 1ns/1ps
`include "casa_regs.vh"
module casa_adapter #(
  parameter FIFO_DEPTH = `CASA_FIFO_DEPTH
) (
  // clock and reset
  input  wire       CLK_I,
  input  wire       RESET_N_I,
  // command port
  input  wire       CMD_STB_I,
  input  wire [2:0] CMD_CODE_I,
  input  wire [7:0] CMD_DATA_I,
  output reg  [7:0] RDATA_O,
  output reg        RDATA_VALID_O,
  // interrupt requests
  output reg        IRQ_RX_O,
  output reg        IRQ_TX_O,
  // serial and modem lines
  output reg        TXD_O,
  input  wire       RXD_I,
  output reg        RTS_O,
  output reg        DTR_O,
  input  wire       CTS_I,
  input  wire       DSR_I
);
  // tx states
  localparam TS_IDLE = 4'b0001;
  localparam TS_LOAD = 4'b0010;
  localparam TS_SHFT = 4'b0100;
  localparam TS_DONE = 4'b1000;
  // rx states
  localparam RS_IDLE = 4'b0001;
  localparam RS_STRT = 4'b0010;
  localparam RS_DATA = 4'b0100;
  localparam RS_STOP = 4'b1000;

  reg        sel_q;            // adapter selected
  reg [3:0]  modem_q;          // modem control byte low nibble
  reg [7:0]  param_q;          // line parameter byte
  reg        txneed_q;         // character needed flag
  reg        rxavail_q;        // character available flag
  reg        err_q;            // parity/overrun/framing flag
  reg [7:0]  rxhold_q;         // last delivered character
  reg [15:0] tick_cnt_q;       // oversample divider
  reg        tick_q;           // one-cycle oversample tick
  reg [15:0] div_d;            // divider for chosen baud

  // tx side
  reg [3:0]  ts_q;             // tx state
  reg [11:0] tsh_q;            // tx shift register, lsb out first
  reg [3:0]  tbits_q;          // bits left in frame
  reg [3:0]  tsub_q;           // tick count within bit
  reg [7:0]  thold_q;          // byte waiting to go

  // rx side
  reg [3:0]  rs_q;             // rx state
  reg [3:0]  rsub_q;           // tick count within bit
  reg [3:0]  rbits_q;          // data and parity bits left
  reg [8:0]  rsh_q;            // data plus parity collected
  reg        rpar_q;           // parity error seen
  reg        push_q;           // completed character strobe
  reg [8:0]  pword_q;          // completed char, bit 8 = bad frame

  wire       stb_sel;          // decoded strobes
  wire       act;
  wire       c_clear;
  wire       c_write;
  wire       c_read;
  wire       f_in_rdy;
  wire       f_out_vld;
  wire [8:0] f_out;
  wire       f_pop;
  wire [3:0] dbits;            // data bits per frame
  wire       par_en;

  assign stb_sel = CMD_STB_I & (CMD_CODE_I == `CASA_CMD_SEL);
  assign act     = CMD_STB_I & sel_q;                        // see [RULE3]
  assign c_clear = act & (CMD_CODE_I == `CASA_CMD_CLEAR);
  assign c_write = act & (CMD_CODE_I == `CASA_CMD_WRITE);
  assign c_read  = act & (CMD_CODE_I == `CASA_CMD_READ);
  assign dbits   = param_q[`CASA_PR_EIGHT] ? 4'h8 : 4'h7;
  assign par_en  = ~param_q[`CASA_PR_NOPAR];
  // drain fifo into holding register when holding is free
  assign f_pop   = f_out_vld & (~rxavail_q | c_read) & ~c_clear;

  // baud divider: clock / (16 * baud), rounded; 134.5 gives 9294
  always @* begin
    case (param_q[3:0])                                      // see [RULE16]
      4'h0:    div_d = 16'd25000;
      4'h1:    div_d = 16'd16667;
      4'h2:    div_d = 16'd11364;
      4'h3:    div_d = 16'd9294;
      4'h4:    div_d = 16'd8333;
      4'h5:    div_d = 16'd4167;
      4'h6:    div_d = 16'd2083;
      4'h7:    div_d = 16'd1042;
      4'h8:    div_d = 16'd694;
      4'h9:    div_d = 16'd625;
      4'ha:    div_d = 16'd521;
      4'hb:    div_d = 16'd347;
      4'hc:    div_d = 16'd260;
      4'hd:    div_d = 16'd174;
      4'he:    div_d = 16'd130;
      default: div_d = 16'd65;
    endcase
  end

  // shared oversample tick for both directions
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q >= div_d - 16'h0001) begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
      tick_q     <= 1'b0;
    end
  end

  // selection and configuration registers
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sel_q   <= 1'b0;
      modem_q <= 4'h0;
      param_q <= `CASA_PR_RESET;
    end else begin
      if (stb_sel) begin
        sel_q <= (CMD_DATA_I == `CASA_SEL_CODE);             // see [RULE2]
      end
      if (c_clear) begin
        modem_q <= 4'h0;                                     // see [RULE4]
      end else if (act & (CMD_CODE_I == `CASA_CMD_MODEM)) begin
        modem_q <= CMD_DATA_I[3:0];                          // see [RULE14]
      end
      if (act & (CMD_CODE_I == `CASA_CMD_PARAM)) begin
        param_q <= CMD_DATA_I;                               // see [RULE15] [RULE17]
      end
    end
  end

  // flags, holding register and read answers
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      txneed_q      <= 1'b1;
      rxavail_q     <= 1'b0;
      err_q         <= 1'b0;
      rxhold_q      <= 8'h00;
      RDATA_O       <= 8'h00;
      RDATA_VALID_O <= 1'b0;
    end else begin
      RDATA_VALID_O <= 1'b0;
      if (act & (CMD_CODE_I == `CASA_CMD_STATUS)) begin
        RDATA_O       <= {rxavail_q, txneed_q, err_q, CTS_I, 2'b00, DSR_I, 1'b0}; // see [RULE7] [RULE9]
        RDATA_VALID_O <= 1'b1;
      end else if (c_read) begin
        RDATA_O       <= rxhold_q;                           // see [RULE12]
        RDATA_VALID_O <= 1'b1;
      end
      // transmit-needed: done wins over write
      if (c_clear) begin
        txneed_q <= 1'b1;                                    // see [RULE5]
      end else if (ts_q == TS_DONE) begin
        txneed_q <= 1'b1;
      end else if (c_write) begin
        txneed_q <= 1'b0;                                    // see [RULE10]
      end
      // receive holding and flags
      if (c_clear) begin
        rxavail_q <= 1'b0;                                   // see [RULE4]
        err_q     <= 1'b0;
      end else begin
        if (f_pop) begin
          rxhold_q  <= f_out[7:0];
          rxavail_q <= 1'b1;
          err_q     <= f_out[8];                             // see [RULE8]
        end else if (c_read) begin
          rxavail_q <= 1'b0;                                 // see [RULE12]
        end
        if (push_q & ~f_in_rdy) begin
          err_q <= 1'b1;                                     // see [RULE21]
        end
      end
    end
  end

  // transmitter: start, data lsb first, parity, stop bits
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ts_q    <= TS_IDLE;
      tsh_q   <= 12'hfff;
      tbits_q <= 4'h0;
      tsub_q  <= 4'h0;
      thold_q <= 8'h00;
    end else if (c_clear) begin
      ts_q  <= TS_IDLE;                                      // see [RULE4]
      tsh_q <= 12'hfff;
    end else begin
      case (ts_q)
        TS_IDLE: begin
          if (c_write) begin
            thold_q <= CMD_DATA_I;
            ts_q    <= TS_LOAD;
          end
        end
        TS_LOAD: begin
          // build frame, stop bits are the ones above
          tsh_q <= param_q[`CASA_PR_EIGHT] ?
                   (par_en ? {2'b11, ^thold_q ^ ~param_q[`CASA_PR_EVEN], thold_q, 1'b0} :
                             {3'b111, thold_q, 1'b0}) :
                   (par_en ? {3'b111, ^thold_q[6:0] ^ ~param_q[`CASA_PR_EVEN],
                              thold_q[6:0], 1'b0} :
                             {4'b1111, thold_q[6:0], 1'b0});   // see [RULE20]
          tbits_q <= 4'h1 + dbits + {3'b000, par_en} +
                     (param_q[`CASA_PR_TWOSTOP] ? 4'h2 : 4'h1);
          tsub_q  <= 4'h0;
          ts_q    <= TS_SHFT;
        end
        TS_SHFT: begin
          if (tick_q) begin
            tsub_q <= tsub_q + 4'h1;
            if (tsub_q == 4'hf) begin
              tsh_q   <= {1'b1, tsh_q[11:1]};
              tbits_q <= tbits_q - 4'h1;
              if (tbits_q == 4'h1) begin
                ts_q <= TS_DONE;
              end
            end
          end
        end
        TS_DONE: ts_q <= TS_IDLE;
        default: ts_q <= TS_IDLE;
      endcase
    end
  end

  // serial and modem outputs, break forces spacing
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      TXD_O    <= 1'b1;
      RTS_O    <= 1'b0;
      DTR_O    <= 1'b0;
      IRQ_RX_O <= 1'b0;
      IRQ_TX_O <= 1'b0;
    end else begin
      TXD_O    <= modem_q[`CASA_MC_BREAK] ? 1'b0 :
                  ((ts_q == TS_SHFT) ? tsh_q[0] : 1'b1);     // see [RULE14] [RULE1]
      RTS_O    <= modem_q[`CASA_MC_RTS];
      DTR_O    <= modem_q[`CASA_MC_DTR];
      IRQ_RX_O <= rxavail_q;                                 // see [RULE18]
      IRQ_TX_O <= txneed_q;                                  // see [RULE19]
    end
  end

  // receiver: samples mid-bit at tick 8
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rs_q    <= RS_IDLE;
      rsub_q  <= 4'h0;
      rbits_q <= 4'h0;
      rsh_q   <= 9'h000;
      push_q  <= 1'b0;
      pword_q <= 9'h000;
    end else if (c_clear) begin
      rs_q   <= RS_IDLE;                                     // see [RULE4]
      push_q <= 1'b0;
    end else begin
      push_q <= 1'b0;
      case (rs_q)
        RS_IDLE: begin
          rsub_q <= 4'h0;
          if (~RXD_I) begin
            rs_q <= RS_STRT;
          end
        end
        RS_STRT: begin
          if (tick_q) begin
            rsub_q <= rsub_q + 4'h1;
            if (rsub_q == 4'h7) begin
              rsub_q  <= 4'h0;
              rbits_q <= dbits + {3'b000, par_en};
              rsh_q   <= 9'h000;
              rs_q    <= RXD_I ? RS_IDLE : RS_DATA;          // glitch rejected
            end
          end
        end
        RS_DATA: begin
          if (tick_q) begin
            rsub_q <= rsub_q + 4'h1;
            if (rsub_q == 4'hf) begin
              rsh_q   <= {RXD_I, rsh_q[8:1]};
              rbits_q <= rbits_q - 4'h1;
              if (rbits_q == 4'h1) begin
                rs_q <= RS_STOP;
              end
            end
          end
        end
        RS_STOP: begin
          if (tick_q) begin
            rsub_q <= rsub_q + 4'h1;
            if (rsub_q == 4'hf) begin
              push_q <= 1'b1;
              rs_q   <= RS_IDLE;
              // align collected bits and check parity and stop
              pword_q <= {~RXD_I | (par_en & rpar_q),
                          rx_data(rsh_q, dbits, par_en)};    // see [RULE21]
            end
          end
        end
        default: rs_q <= RS_IDLE;
      endcase
    end
  end

  // parity error detector, combinational over collected bits
  always @* begin
    if (param_q[`CASA_PR_EIGHT]) begin
      rpar_q = par_en & ((^rsh_q[8:0]) ^ ~param_q[`CASA_PR_EVEN]);
    end else begin
      rpar_q = par_en & ((^rsh_q[8:1]) ^ ~param_q[`CASA_PR_EVEN]);
    end
  end

  // right-align received data bits
  function [7:0] rx_data;
    input [8:0] sh;
    input [3:0] nb;
    input       pe;
    begin
      case ({nb == 4'h8, pe})
        2'b11:   rx_data = sh[7:0];
        2'b10:   rx_data = sh[8:1];
        2'b01:   rx_data = {1'b0, sh[7:1]};
        default: rx_data = {1'b0, sh[8:2]};
      endcase
    end
  endfunction

  // receive buffer between deserialiser and holding register
  casa_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH),
    .AW    (3)
  ) u_rxfifo (
    .clk_i       (CLK_I),
    .reset_n_i   (RESET_N_I),
    .in_valid_i  (push_q),
    .in_ready_o  (f_in_rdy),
    .in_data_i   (pword_q),
    .out_valid_o (f_out_vld),
    .out_ready_i (f_pop),
    .out_data_o  (f_out)
  );
endmodule // casa_adapter

// File: hw/casa_fifo.v
/*
  small synchronous fifo with valid/ready on both sides.
  assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module casa_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             clk_i,
  input  wire             reset_n_i,
  // fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];  // storage
  reg [AW-1:0]    wr_q;               // write pointer
  reg [AW-1:0]    rd_q;               // read pointer
  reg [AW:0]      cnt_q;              // fill level
  wire            push;               // accepted write
  wire            pop;                // accepted read

  assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // storage write, no reset needed
  always @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // pointers and level
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // casa_fifo

// File: pkg/casa_regs.vh
/*
  constants for the command-driven async serial adapter: command codes,
  status and control bit positions, baud divider table inputs.
  assumes inclusion by the adapter top, its checker and the bench.
*/
`ifndef CASA_REGS_VH
`define CASA_REGS_VH

// select code naming this adapter
`define CASA_SEL_CODE        8'hf0
// command codes on the command port
`define CASA_CMD_SEL         3'h0
`define CASA_CMD_CLEAR       3'h1
`define CASA_CMD_STATUS      3'h2
`define CASA_CMD_WRITE       3'h3
`define CASA_CMD_READ        3'h4
`define CASA_CMD_MODEM       3'h5
`define CASA_CMD_PARAM       3'h6
// status byte bits
`define CASA_ST_RXAVAIL      7
`define CASA_ST_TXNEED       6
`define CASA_ST_ERROR        5
`define CASA_ST_CTS          4
`define CASA_ST_DSR          1
// modem control bits
`define CASA_MC_BREAK        3
`define CASA_MC_DTR          1
`define CASA_MC_RTS          0
// parameter byte bits
`define CASA_PR_TWOSTOP      7
`define CASA_PR_EIGHT        6
`define CASA_PR_NOPAR        5
`define CASA_PR_EVEN         4
// reset value of parameter byte: 1 stop, 7 bits, odd parity, 9600
`define CASA_PR_RESET        8'h0e
// clock rate in hz and oversampling
`define CASA_CLK_HZ          20000000
`define CASA_OVS             16
// receive fifo depth
`define CASA_FIFO_DEPTH      8

`endif
